// ==== clc_pkg.sv ====
package clc_pkg;

  // ----------------------------------------
  // Charge stages
  // ----------------------------------------
  typedef enum logic [2:0] {
    STG_IDLE,
    STG_DEAD,
    STG_SHORT,
    STG_PRE,
    STG_CC,
    STG_CV
  } clc_stage_t;

  // ----------------------------------------
  // Battery voltage thresholds in mV
  // ----------------------------------------
  localparam logic [15:0] VBAT_DEAD_MV = 16'h0bb8;
  localparam logic [15:0] VBAT_SHORT_MV = 16'h1388;
  localparam logic [15:0] VBAT_LOW_MV = 16'h1770;
  localparam logic [15:0] VBAT_TERM_MV = 16'h20d0;

  // ----------------------------------------
  // Currents and percentage codes
  // ----------------------------------------
  localparam logic [12:0] DEAD_CURRENT_MA = 13'h000a;
  localparam logic [12:0] CURRENT_OFF_MA = 13'h0000;
  localparam logic [12:0] ALLOW_MAX_MA = 13'h1fff;
  localparam logic [12:0] ALLOW_STEP_MA = 13'h000a;
  localparam logic [6:0] PCT_ZERO = 7'h00;
  localparam logic [6:0] PCT_FLOOR = 7'h01;
  localparam logic [6:0] PCT_CEIL = 7'h64;
  localparam logic [19:0] PCT_DIVISOR = 20'h00064;
  localparam logic [6:0] SHORT_PCT_BASE = 7'h01;
  localparam logic [6:0] PRE_PCT_BASE = 7'h05;
  localparam logic [6:0] PRE_PCT_STEP = 7'h05;

  // ----------------------------------------
  // Minimum input voltage in mV
  // ----------------------------------------
  localparam logic [15:0] VIN_BASE_MV = 16'h0fa0;
  localparam logic [15:0] VIN_STEP_MV = 16'h0064;

  // ----------------------------------------
  // Thermal and timing
  // ----------------------------------------
  localparam logic [1:0] HOT_OFF_SEL = 2'h3;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIMER_TICK_NS = 1000000;
  localparam int TIMER_TICK_CYCLES = TIMER_TICK_NS / CLK_PERIOD_NS;
  localparam int ADJUST_NS = 64;
  localparam int ADJUST_CYCLES = ADJUST_NS / CLK_PERIOD_NS;

endpackage

// ==== clc_rate_halver.sv ====
module clc_rate_halver (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tickIn,
  input wire logic halve,
  output logic tickOut
);

  logic phase_ff;
  logic nxt_phase;

  // ----------------------------------------
  // Pass every tick, or every second one
  // ----------------------------------------
  always_comb begin
    nxt_phase = phase_ff;
    if (tickIn && halve) begin
      nxt_phase = ~phase_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Tick handshake may be combinational
  assign tickOut = tickIn && (!halve || phase_ff); // R11 R15

  a_half_drop: assert property (@(posedge clk) disable iff (!rstn)
    (tickIn && halve && !phase_ff) |-> !tickOut) // R11
    else $error("halved timer ticked on skipped phase");

endmodule // clc_rate_halver

// ==== clc_charge_limit_control.sv ====
// Functional notes
// (R1) Stage follows battery voltage: dead, short, precharge, constant current, voltage.
// (R2) Dead stage delivers a fixed 10 mA regardless of scaling.
// (R3) Short stage current is a fraction chosen by the short-current field.
// (R4) Short fraction is 1, 2, 4 or 8 percent of hardware limit.
// (R5) Precharge current is 5 to 20 percent of fast-charge current.
// (R6) Reaching input current limit reduces charge current to hold the limit.
// (R7) Input limit equals hardware limit times 7-bit percent code, 1 to 100.
// (R8) Code zero reads back zero but applies one percent.
// (R9) Codes above 100 read back unchanged but apply 100 percent.
// (R10) Input current limiting raises its status flag.
// (R11) Current limiting halves both safety timer rates.
// (R12) Input at minimum voltage reduces charge current to hold the minimum.
// (R13) Minimum input voltage is 4.0 V plus 0.1 V per code step.
// (R14) Input voltage limiting raises its status flag.
// (R15) Voltage limiting halves both safety timer rates.
// (R16) Temperature supervision acts in charge and reverse-supply modes.
// (R17) Temperature outside window reports a fault and halts charging.
// (R18) Thermal disable set ignores the thermistor comparators entirely.
// (R19) Two schemes: banded standard scheme or simple hot and cold thresholds.
// (R20) Both limits together set both flags; the lower allowance governs.
module clc_charge_limit_control #(
  parameter int unsigned TICK_CYCLES = clc_pkg::TIMER_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic chargeMode,
  input wire logic reverseMode,
  input wire logic [15:0] batteryMv,
  input wire logic [15:0] inputMv,
  input wire logic [12:0] inputCurrentMa,
  input wire logic [12:0] hwChargeLimitMa,
  input wire logic [12:0] inputLimitSetPinMa,
  input wire logic [6:0] fastChargeScaleCode,
  input wire logic [1:0] shortCurrentSelect,
  input wire logic [1:0] prechargeCurrentSelect,
  input wire logic [6:0] inputLimitPercentCode,
  input wire logic [6:0] minInputVoltageCode,
  input wire logic thermalMonitorDisable,
  input wire logic bandedSchemeDisable,
  input wire logic tempBelowZero,
  input wire logic tempAboveSixty,
  input wire logic [1:0] hotSelect,
  input wire logic tempAboveHot,
  input wire logic tempBelowCold,
  output clc_pkg::clc_stage_t stage,
  output logic [12:0] chargeCurrentMa,
  output logic [6:0] inputLimitPercentField,
  output logic [6:0] appliedInputPercent,
  output logic [12:0] inputLimitMa,
  output logic [15:0] minInputVoltageMv,
  output logic inputCurrentLimitingFlag,
  output logic inputVoltageLimitingFlag,
  output logic tempFault,
  output logic lowBatteryTimerTick,
  output logic fastChargeTimerTick
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Clamp a percent code to the applied range
  function automatic logic [6:0] clampPct(input logic [6:0] code);
    logic [6:0] res;
    res = code;
    if (code == clc_pkg::PCT_ZERO) begin
      res = clc_pkg::PCT_FLOOR;
    end else if (code > clc_pkg::PCT_CEIL) begin
      res = clc_pkg::PCT_CEIL;
    end
    return res;
  endfunction

  // Scale a current by a percentage
  function automatic logic [12:0] scaleMa(input logic [12:0] ma, input logic [6:0] pct);
    logic [19:0] prod;
    prod = 20'(ma) * 20'(pct);
    return 13'(prod / clc_pkg::PCT_DIVISOR);
  endfunction

  clc_pkg::clc_stage_t stage_ff, nxt_stage;
  logic [6:0] field_ff, nxt_field;
  logic [6:0] inPct_ff, nxt_inPct;
  logic [12:0] inLim_ff, nxt_inLim;
  logic [15:0] vinMin_ff, nxt_vinMin;
  logic curLim_ff, nxt_curLim;
  logic voltLim_ff, nxt_voltLim;
  logic fault_ff, nxt_fault;
  logic [12:0] allow_ff, nxt_allow;
  logic [12:0] charge_ff, nxt_charge;
  logic [17:0] tickCnt_ff, nxt_tickCnt;
  logic [7:0] adjCnt_ff, nxt_adjCnt;
  logic baseTick;
  logic adjStrobe;
  logic anyLimit;
  logic lowTick;
  logic fastTick;

  // ----------------------------------------
  // Stage selection
  // ----------------------------------------
  // Stage from battery voltage, idle on fault
  always_comb begin
    nxt_stage = clc_pkg::STG_IDLE;
    if (chargeMode && !fault_ff) begin
      if (batteryMv < clc_pkg::VBAT_DEAD_MV) begin
        nxt_stage = clc_pkg::STG_DEAD; // R1
      end else if (batteryMv < clc_pkg::VBAT_SHORT_MV) begin
        nxt_stage = clc_pkg::STG_SHORT; // R1
      end else if (batteryMv < clc_pkg::VBAT_LOW_MV) begin
        nxt_stage = clc_pkg::STG_PRE; // R1
      end else if (batteryMv < clc_pkg::VBAT_TERM_MV) begin
        nxt_stage = clc_pkg::STG_CC; // R1
      end else begin
        nxt_stage = clc_pkg::STG_CV; // R1
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage_ff <= clc_pkg::STG_IDLE;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  // ----------------------------------------
  // Input limit code and minimum voltage
  // ----------------------------------------
  // Readback keeps code, applied value clamps
  always_comb begin
    nxt_field = inputLimitPercentCode; // R8 R9
    nxt_inPct = clampPct(inputLimitPercentCode); // R7 R8 R9
    nxt_inLim = scaleMa(inputLimitSetPinMa, nxt_inPct); // R7
    nxt_vinMin = 16'(clc_pkg::VIN_BASE_MV + clc_pkg::VIN_STEP_MV * 16'(minInputVoltageCode)); // R13
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      field_ff <= clc_pkg::PCT_ZERO;
      inPct_ff <= clc_pkg::PCT_FLOOR;
      inLim_ff <= clc_pkg::CURRENT_OFF_MA;
      vinMin_ff <= clc_pkg::VIN_BASE_MV;
    end else begin
      field_ff <= nxt_field;
      inPct_ff <= nxt_inPct;
      inLim_ff <= nxt_inLim;
      vinMin_ff <= nxt_vinMin;
    end
  end

  // ----------------------------------------
  // Limiting detection
  // ----------------------------------------
  // Flags follow the loops while charging
  always_comb begin
    nxt_curLim = chargeMode && (inputCurrentMa >= inLim_ff); // R6 R10
    nxt_voltLim = chargeMode && (inputMv <= vinMin_ff); // R12 R14
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      curLim_ff <= 1'b0;
      voltLim_ff <= 1'b0;
    end else begin
      curLim_ff <= nxt_curLim;
      voltLim_ff <= nxt_voltLim;
    end
  end

  assign anyLimit = curLim_ff || voltLim_ff; // R20

  // ----------------------------------------
  // Temperature supervision
  // ----------------------------------------
  // Window check by selected scheme
  always_comb begin
    nxt_fault = 1'b0;
    if (!thermalMonitorDisable && (chargeMode || reverseMode)) begin // R16 R18
      if (!bandedSchemeDisable) begin
        nxt_fault = tempBelowZero || tempAboveSixty; // R17 R19
      end else begin
        nxt_fault = ((hotSelect != clc_pkg::HOT_OFF_SEL) && tempAboveHot)
          || tempBelowCold; // R17 R19
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= nxt_fault;
    end
  end

  // ----------------------------------------
  // Charge allowance regulation
  // ----------------------------------------
  // Adjust strobe divider
  always_comb begin
    nxt_adjCnt = adjCnt_ff + 8'h01;
    if (adjCnt_ff == 8'(clc_pkg::ADJUST_CYCLES - 1)) begin
      nxt_adjCnt = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adjCnt_ff <= 8'h00;
    end else begin
      adjCnt_ff <= nxt_adjCnt;
    end
  end

  assign adjStrobe = (adjCnt_ff == 8'(clc_pkg::ADJUST_CYCLES - 1));

  // Step down while any limit acts, up otherwise
  always_comb begin
    nxt_allow = allow_ff;
    if (adjStrobe) begin
      if (anyLimit) begin // R6 R12 R20
        if (allow_ff > clc_pkg::ALLOW_STEP_MA) begin
          nxt_allow = allow_ff - clc_pkg::ALLOW_STEP_MA;
        end else begin
          nxt_allow = clc_pkg::CURRENT_OFF_MA;
        end
      end else if (allow_ff < clc_pkg::ALLOW_MAX_MA - clc_pkg::ALLOW_STEP_MA) begin
        nxt_allow = allow_ff + clc_pkg::ALLOW_STEP_MA;
      end else begin
        nxt_allow = clc_pkg::ALLOW_MAX_MA;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      allow_ff <= clc_pkg::ALLOW_MAX_MA;
    end else begin
      allow_ff <= nxt_allow;
    end
  end

  // ----------------------------------------
  // Charge current setpoint
  // ----------------------------------------
  // Stage target, then limited by allowance outside the dead stage
  always_comb begin
    logic [12:0] fastMa;
    logic [12:0] target;
    fastMa = scaleMa(hwChargeLimitMa, clampPct(fastChargeScaleCode));
    target = clc_pkg::CURRENT_OFF_MA;
    case (stage_ff)
      clc_pkg::STG_DEAD: target = clc_pkg::DEAD_CURRENT_MA; // R2
      clc_pkg::STG_SHORT: target = scaleMa(hwChargeLimitMa,
        clc_pkg::SHORT_PCT_BASE << shortCurrentSelect); // R3 R4
      clc_pkg::STG_PRE: target = scaleMa(fastMa, 7'(clc_pkg::PRE_PCT_BASE
        + clc_pkg::PRE_PCT_STEP * 7'(prechargeCurrentSelect))); // R5
      clc_pkg::STG_CC: target = fastMa;
      clc_pkg::STG_CV: target = fastMa;
      default: target = clc_pkg::CURRENT_OFF_MA;
    endcase
    nxt_charge = target;
    if (stage_ff == clc_pkg::STG_IDLE || fault_ff) begin
      nxt_charge = clc_pkg::CURRENT_OFF_MA; // R17
    end else if (stage_ff != clc_pkg::STG_DEAD && target > allow_ff) begin
      nxt_charge = allow_ff; // R6 R12 R20
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      charge_ff <= clc_pkg::CURRENT_OFF_MA;
    end else begin
      charge_ff <= nxt_charge;
    end
  end

  // ----------------------------------------
  // Safety timer ticks
  // ----------------------------------------
  // Base tick divider
  always_comb begin
    nxt_tickCnt = tickCnt_ff + 18'h00001;
    if (tickCnt_ff == 18'(TICK_CYCLES - 1)) begin
      nxt_tickCnt = 18'h00000;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_ff <= 18'h00000;
    end else begin
      tickCnt_ff <= nxt_tickCnt;
    end
  end

  assign baseTick = (tickCnt_ff == 18'(TICK_CYCLES - 1));
  assign lowTick = baseTick && !fault_ff && (stage_ff == clc_pkg::STG_DEAD
    || stage_ff == clc_pkg::STG_SHORT || stage_ff == clc_pkg::STG_PRE);
  assign fastTick = baseTick && !fault_ff
    && (stage_ff == clc_pkg::STG_CC || stage_ff == clc_pkg::STG_CV);

  // Half rate while either limit acts
  clc_rate_halver u_lowHalver (
    .clk(clk),
    .rstn(rstn),
    .tickIn(lowTick),
    .halve(anyLimit), // R11 R15
    .tickOut(lowBatteryTimerTick)
  );

  clc_rate_halver u_fastHalver (
    .clk(clk),
    .rstn(rstn),
    .tickIn(fastTick),
    .halve(anyLimit), // R11 R15
    .tickOut(fastChargeTimerTick)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign stage = stage_ff;
  assign chargeCurrentMa = charge_ff;
  assign inputLimitPercentField = field_ff;
  assign appliedInputPercent = inPct_ff;
  assign inputLimitMa = inLim_ff;
  assign minInputVoltageMv = vinMin_ff;
  assign inputCurrentLimitingFlag = curLim_ff;
  assign inputVoltageLimitingFlag = voltLim_ff;
  assign tempFault = fault_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_dead_fixed: assert property ((stage_ff == clc_pkg::STG_DEAD && !fault_ff) // R2
    |=> charge_ff == clc_pkg::DEAD_CURRENT_MA)
    else $error("dead stage current not fixed");

  a_zero_code: assert property ((inputLimitPercentCode == clc_pkg::PCT_ZERO) // R8
    |=> (field_ff == clc_pkg::PCT_ZERO && inPct_ff == clc_pkg::PCT_FLOOR))
    else $error("zero code not applied as floor");

  a_high_code: assert property ((inputLimitPercentCode > clc_pkg::PCT_CEIL) // R9
    |=> (field_ff == $past(inputLimitPercentCode) && inPct_ff == clc_pkg::PCT_CEIL))
    else $error("high code not saturated");

  a_vin_threshold: assert property ($stable(minInputVoltageCode) // R13
    |=> vinMin_ff == 16'(clc_pkg::VIN_BASE_MV
      + clc_pkg::VIN_STEP_MV * 16'($past(minInputVoltageCode))))
    else $error("minimum input voltage wrong");

  a_cur_flag: assert property ((chargeMode && inputCurrentMa >= inLim_ff) // R10
    |=> curLim_ff)
    else $error("current limiting flag missing");

  a_volt_flag: assert property ((chargeMode && inputMv <= vinMin_ff) // R14
    |=> voltLim_ff)
    else $error("voltage limiting flag missing");

  a_both_flags: assert property ((nxt_curLim && nxt_voltLim) // R20
    |=> (inputCurrentLimitingFlag && inputVoltageLimitingFlag))
    else $error("both limits not flagged");

  a_allow_down: assert property ((adjStrobe && anyLimit && allow_ff > clc_pkg::ALLOW_STEP_MA) // R6
    |=> allow_ff == $past(allow_ff) - clc_pkg::ALLOW_STEP_MA)
    else $error("allowance not reduced under limiting");

  a_fault_halt: assert property (fault_ff [*2] |=> charge_ff == clc_pkg::CURRENT_OFF_MA) // R17
    else $error("charging not halted on fault");

  a_th_ignored: assert property (thermalMonitorDisable |=> !fault_ff) // R18
    else $error("fault raised with supervision disabled");

  a_stage_idle: assert property ((!chargeMode || fault_ff) // R1
    |=> stage_ff == clc_pkg::STG_IDLE)
    else $error("stage not idle");

  c_reach_cc: cover property (stage_ff == clc_pkg::STG_PRE ##[1:20] stage_ff == clc_pkg::STG_CC);
  c_both_limits: cover property (curLim_ff && voltLim_ff);
  c_fault_rev: cover property (reverseMode && fault_ff);
  c_half_tick: cover property (fastChargeTimerTick && anyLimit);

endmodule // clc_charge_limit_control

// ==== clc_source_model.sv ====
module clc_source_model (
  input wire logic [12:0] chargeCurrentMa,
  input wire logic [15:0] sourceMv,
  input wire logic [12:0] loadMa,
  output logic [12:0] inputCurrentMa,
  output logic [15:0] inputMv
);
  timeunit 1ns;
  timeprecision 1ps;

  // Source current follows the charge setpoint plus any extra load
  assign inputCurrentMa = chargeCurrentMa + loadMa;
  // Weak source sags by 1 mV for every 4 mA drawn
  assign inputMv = sourceMv - {5'h00, inputCurrentMa[12:2]};
endmodule // clc_source_model

// ==== clc_charge_limit_control_tb_top.sv ====
module clc_charge_limit_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int kind; int exp; int due;} clc_note_t;

  // ------------------------------------------
  // Signals
  // ------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic chargeMode = 1'b0;
  logic reverseMode = 1'b0;
  logic [15:0] batteryMv = 16'h0000;
  logic [15:0] sourceMv = 16'h2ee0;
  logic [12:0] loadMa = 13'h0000;
  logic [15:0] inputMv;
  logic [12:0] inputCurrentMa;
  logic [12:0] hwChargeLimitMa = 13'h0fa0;
  logic [12:0] inputLimitSetPinMa = 13'h0000;
  logic [6:0] fastChargeScaleCode = 7'h32;
  logic [1:0] shortCurrentSelect = 2'h0;
  logic [1:0] prechargeCurrentSelect = 2'h0;
  logic [6:0] inputLimitPercentCode = 7'h00;
  logic [6:0] minInputVoltageCode = 7'h00;
  logic [8:0] tv = 9'h000;
  clc_pkg::clc_stage_t stage;
  logic [12:0] chargeCurrentMa;
  logic [6:0] inputLimitPercentField;
  logic [6:0] appliedInputPercent;
  logic [12:0] inputLimitMa;
  logic [15:0] minInputVoltageMv;
  logic inputCurrentLimitingFlag;
  logic inputVoltageLimitingFlag;
  logic tempFault;
  logic lowBatteryTimerTick;
  logic fastChargeTimerTick;
  int miscompares = 0;
  int totalChecks = 0;
  int cyc = 0;
  int fastCnt = 0;
  int lowCnt = 0;
  int seed = 61;
  clc_note_t notes[$];

  // Clock and cycle count
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    fastCnt <= fastCnt + int'(fastChargeTimerTick);
    lowCnt <= lowCnt + int'(lowBatteryTimerTick);
  end

  clc_charge_limit_control #(.TICK_CYCLES(20)) dut (
    .clk(clk), .rstn(rstn), .chargeMode(chargeMode), .reverseMode(reverseMode),
    .batteryMv(batteryMv), .inputMv(inputMv), .inputCurrentMa(inputCurrentMa),
    .hwChargeLimitMa(hwChargeLimitMa), .inputLimitSetPinMa(inputLimitSetPinMa),
    .fastChargeScaleCode(fastChargeScaleCode), .shortCurrentSelect(shortCurrentSelect),
    .prechargeCurrentSelect(prechargeCurrentSelect),
    .inputLimitPercentCode(inputLimitPercentCode), .minInputVoltageCode(minInputVoltageCode),
    .thermalMonitorDisable(tv[7]), .bandedSchemeDisable(tv[6]), .tempBelowZero(tv[5]),
    .tempAboveSixty(tv[4]), .hotSelect(tv[3:2]), .tempAboveHot(tv[1]),
    .tempBelowCold(tv[0]), .stage(stage), .chargeCurrentMa(chargeCurrentMa),
    .inputLimitPercentField(inputLimitPercentField),
    .appliedInputPercent(appliedInputPercent), .inputLimitMa(inputLimitMa),
    .minInputVoltageMv(minInputVoltageMv),
    .inputCurrentLimitingFlag(inputCurrentLimitingFlag),
    .inputVoltageLimitingFlag(inputVoltageLimitingFlag), .tempFault(tempFault),
    .lowBatteryTimerTick(lowBatteryTimerTick), .fastChargeTimerTick(fastChargeTimerTick)
  );

  clc_source_model source (
    .chargeCurrentMa(chargeCurrentMa), .sourceMv(sourceMv), .loadMa(loadMa),
    .inputCurrentMa(inputCurrentMa), .inputMv(inputMv)
  );

  // ------------------------------------------
  // Checking
  // ------------------------------------------
  task automatic check(input int kind, input logic [15:0] seen, input logic [15:0] expected);
    totalChecks++;
    if (seen !== expected) begin
      miscompares++;
      $display("CHECK FAILED at %0t: kind %0d seen %0h expected %0h", $time, kind, seen,
               expected);
    end
  endtask

  // Takes due notes off the queue and compares them with the outputs
  always @(negedge clk) begin
    clc_note_t n;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      n = notes.pop_front();
      case (n.kind)
        0: check(0, {13'h0000, stage}, n.exp[15:0]);
        1: check(1, {3'h0, chargeCurrentMa}, n.exp[15:0]);
        2: check(2, {9'h000, inputLimitPercentField}, n.exp[15:0]);
        3: check(3, {9'h000, appliedInputPercent}, n.exp[15:0]);
        4: check(4, {3'h0, inputLimitMa}, n.exp[15:0]);
        5: check(5, minInputVoltageMv, n.exp[15:0]);
        6: check(6, {15'h0000, inputCurrentLimitingFlag}, n.exp[15:0]);
        7: check(7, {15'h0000, inputVoltageLimitingFlag}, n.exp[15:0]);
        8: check(8, {15'h0000, tempFault}, n.exp[15:0]);
        9: check(9, {15'h0000, chargeCurrentMa < n.exp}, 16'h0001);
        10: check(10, {15'h0000, fastCnt >= n.exp - 1 && fastCnt <= n.exp + 1}, 16'h0001);
        default: check(11, {15'h0000, lowCnt >= n.exp - 1 && lowCnt <= n.exp + 1}, 16'h0001);
      endcase
    end
  end

  // ------------------------------------------
  // Driver tasks
  // ------------------------------------------
  task automatic note(input int kind, input int value, input int delay);
    notes.push_back('{kind, value, cyc + delay});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic done(input string name);
    cycles(5);
    $display("test %s done", name);
  endtask

  task automatic ticks(input int kind, input int expected);
    fastCnt = 0;
    lowCnt = 0;
    cycles(400);
    note(kind, expected, 0);
    cycles(2);
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  initial begin
    automatic int codes[6] = '{0, 1, 60, 100, 101, 127};
    int code;
    int mcode;
    int pin;
    int app;
    automatic logic [8:0] thermal[8] = '{9'h120, 9'h110, 9'h0b0, 9'h142, 9'h04e, 9'h145,
      9'h003, 9'h070};
    cycles(2);
    rstn = 1'b1;
    note(0, clc_pkg::STG_IDLE, 1);
    note(1, 0, 1);
    note(2, 0, 1);
    note(3, 1, 1);
    note(4, 0, 1);
    note(5, 4000, 1);
    note(6, 0, 1);
    note(8, 0, 1);
    done("reset");
    for (int i = 0; i < 10; i++) begin
      code = (i < 6) ? codes[i] : ($random(seed) & 127);
      mcode = $random(seed) & 127;
      pin = 1000 + ($random(seed) & 4095);
      app = (code == 0) ? 1 : ((code > 100) ? 100 : code);
      inputLimitPercentCode = 7'(code);
      minInputVoltageCode = 7'(mcode);
      inputLimitSetPinMa = 13'(pin);
      note(2, code, 3);
      note(3, app, 3);
      note(4, pin * app / 100, 3);
      note(5, 4000 + 100 * mcode, 3);
      cycles(4);
    end
    inputLimitPercentCode = 7'h64;
    inputLimitSetPinMa = 13'h1f40;
    minInputVoltageCode = 7'h00;
    done("codes");
    chargeMode = 1'b1;
    batteryMv = 16'h07d0;
    note(0, clc_pkg::STG_DEAD, 3);
    note(1, 10, 3);
    cycles(4);
    fastChargeScaleCode = 7'h00;
    note(1, 10, 3);
    cycles(4);
    ticks(11, 20);
    fastChargeScaleCode = 7'h32;
    batteryMv = 16'h0fa0;
    for (int s = 0; s < 4; s++) begin
      shortCurrentSelect = 2'(s);
      note(0, clc_pkg::STG_SHORT, 3);
      note(1, 4000 * (1 << s) / 100, 3);
      cycles(4);
    end
    batteryMv = 16'h157c;
    for (int s = 0; s < 4; s++) begin
      prechargeCurrentSelect = 2'(s);
      note(0, clc_pkg::STG_PRE, 3);
      note(1, 2000 * (5 + 5 * s) / 100, 3);
      cycles(4);
    end
    batteryMv = 16'h2134;
    note(0, clc_pkg::STG_CV, 3);
    cycles(4);
    batteryMv = 16'h1b58;
    note(0, clc_pkg::STG_CC, 3);
    note(1, 2000, 3);
    cycles(4);
    ticks(10, 20);
    done("stages");
    for (int t = 0; t < 8; t++) begin
      tv = thermal[t];
      note(8, tv[8], 3);
      if (tv[8]) begin
        note(0, clc_pkg::STG_IDLE, 3);
        note(1, 0, 3);
      end
      cycles(4);
      tv = 9'h000;
      cycles(6);
    end
    chargeMode = 1'b0;
    reverseMode = 1'b1;
    tv = 9'h020;
    note(8, 1, 3);
    cycles(4);
    tv = 9'h000;
    reverseMode = 1'b0;
    chargeMode = 1'b1;
    done("thermal");
    cycles(6);
    inputLimitSetPinMa = 13'h03e8;
    note(6, 1, 4);
    note(7, 0, 4);
    cycles(5);
    ticks(10, 10);
    cycles(11000);
    note(9, 2000, 0);
    cycles(2);
    minInputVoltageCode = 7'h7f;
    note(6, 1, 4);
    note(7, 1, 4);
    cycles(5);
    inputLimitSetPinMa = 13'h1f40;
    note(6, 0, 4);
    note(7, 1, 4);
    cycles(5);
    batteryMv = 16'h157c;
    cycles(4);
    ticks(11, 10);
    done("limits");
    conclude();
  end
endmodule // clc_charge_limit_control_tb_top
